// file: pfp_pkg.sv
// Package of constants and types for the parallel flash programming port.
package pfp_pkg;

	// ==========================================================
	// Transfer selector codes
	localparam logic [3:0] SEL_COMMAND_ENTRY = 4'h0;
	localparam logic [3:0] SEL_ADDRESS_BYTE_LOW = 4'h1;
	localparam logic [3:0] SEL_ADDRESS_BYTE_NEXT = 4'h2;
	localparam logic [3:0] SEL_DATA = 4'h5;

	// ==========================================================
	// Command codes
	localparam logic [15:0] CMD_READ = 16'h0011;
	localparam logic [15:0] CMD_PAGE_WRITE = 16'h0012;
	localparam logic [15:0] CMD_PAGE_WRITE_LOCK = 16'h0022;
	localparam logic [15:0] CMD_ERASE_WRITE_PAGE = 16'h0032;
	localparam logic [15:0] CMD_ERASE_WRITE_LOCK = 16'h0042;
	localparam logic [15:0] CMD_ERASE_EVERYTHING = 16'h0013;
	localparam logic [15:0] CMD_SET_LOCK = 16'h0014;
	localparam logic [15:0] CMD_CLEAR_LOCK = 16'h0024;
	localparam logic [15:0] CMD_GET_LOCK = 16'h0015;
	localparam logic [15:0] CMD_SET_NVM_BIT = 16'h0034;
	localparam logic [15:0] CMD_CLEAR_NVM_BIT = 16'h0044;
	localparam logic [15:0] CMD_GET_NVM_BIT = 16'h0025;
	localparam logic [15:0] CMD_SET_SECURITY = 16'h0054;
	localparam logic [15:0] CMD_GET_SECURITY = 16'h0035;
	localparam logic [15:0] CMD_WRITE_MEMORY = 16'h001f;
	localparam logic [15:0] CMD_SELECT_CONTROLLER = 16'h0016;
	localparam logic [15:0] CMD_GET_VERSION = 16'h001e;

	// ==========================================================
	// Reset values and timing
	localparam logic [15:0] COMMAND_RESET = 16'h0000;
	localparam logic [31:0] ADDRESS_RESET = 32'h0000_0000;
	localparam int EXT_CLOCK_MIN_HZ = 32000;
	localparam int CLK_HZ = 100000000;
	// Cycles of clk in one external clock period at the least frequency.
	localparam int EXT_CLOCK_WINDOW = CLK_HZ / EXT_CLOCK_MIN_HZ;

	// ==========================================================
	// Operation decoded from a command word
	typedef enum logic [4:0]
	{
		OP_NONE = 5'h00,
		OP_READ = 5'h01,
		OP_PAGE_WRITE = 5'h02,
		OP_PAGE_WRITE_LOCK = 5'h03,
		OP_ERASE_WRITE_PAGE = 5'h04,
		OP_ERASE_WRITE_LOCK = 5'h05,
		OP_ERASE_EVERYTHING = 5'h06,
		OP_SET_LOCK = 5'h07,
		OP_CLEAR_LOCK = 5'h08,
		OP_GET_LOCK = 5'h09,
		OP_SET_NVM_BIT = 5'h0a,
		OP_CLEAR_NVM_BIT = 5'h0b,
		OP_GET_NVM_BIT = 5'h0c,
		OP_SET_SECURITY = 5'h0d,
		OP_GET_SECURITY = 5'h0e,
		OP_WRITE_MEMORY = 5'h0f,
		OP_SELECT_CONTROLLER = 5'h10,
		OP_GET_VERSION = 5'h11
	} pfp_op_t;

	// Handshake states.
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_LATCH = 3'b001,
		ST_EXECUTE = 3'b010,
		ST_WAIT_READ = 3'b011,
		ST_DRIVE = 3'b100,
		ST_RELEASE = 3'b101,
		ST_WAIT_HIGH = 3'b110
	} pfp_state_t;

endpackage

// file: pfp_port.sv
// Device end of the parallel flash programming port.
//
// Operation
// - Decode selector: command, address bytes, data.
// - Command selector stores bus word as command only if it is a recognised code.
// - Recognise read and page write command codes.
// - Recognise erase, lock, NVM, security codes.
// - Recognise write memory, controller select, version.
// - Handshake ends with strobe and ready high.
// - Latch selector and data on strobe fall.
// - Drop ready on the same edge that latches the transfer.
// - Execute, poll strobe high, then raise ready.
// - Use external clock above 32 kHz if present before the first strobe.
// - Output valid low when bus is input.
// - Ready high when idle; strobes active low.
// - Port works only with test selects high.
// - Read drives bus while output enable low.
// - Address increments after each data handshake.
`timescale 1ns/10ps
`default_nettype none

module pfp_port
	import pfp_pkg::*;
#(
	parameter int DATA_WIDTH = 16,
	parameter int ADDR_WIDTH = 32,
	parameter int EXEC_CYCLES = 2
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic test_select,
	input wire logic program_select_0,
	input wire logic program_select_1,
	input wire logic external_clock_in,
	input wire logic command_strobe_n,
	input wire logic output_enable_n,
	input wire logic [3:0] transfer_selector,
	input wire logic [DATA_WIDTH-1:0] port_data_bus_in,
	output logic [DATA_WIDTH-1:0] port_data_bus_out,
	output logic port_data_bus_oe,
	output logic port_ready,
	output logic output_valid_n,
	output logic use_external_clock,
	output logic [15:0] command_word,
	output logic [ADDR_WIDTH-1:0] flash_address,
	output logic flash_write_valid,
	output logic [DATA_WIDTH-1:0] flash_write_data,
	output logic flash_read_strobe,
	input wire logic [DATA_WIDTH-1:0] flash_read_data,
	output logic command_valid,
	output logic [4:0] operation
);

	// The execute counter is eight bits wide, so at most 256 cycles.
	if (DATA_WIDTH != 16 || ADDR_WIDTH < 16 || EXEC_CYCLES < 1
		|| EXEC_CYCLES > 256)
	begin
		$error("pfp_port: unsupported parameter values.");
	end

	// ==========================================================
	// Command decoding
	function automatic pfp_op_t decode_command(input logic [15:0] code);
		case (code)
			CMD_READ: decode_command = OP_READ;
			CMD_PAGE_WRITE: decode_command = OP_PAGE_WRITE;
			CMD_PAGE_WRITE_LOCK: decode_command = OP_PAGE_WRITE_LOCK;
			CMD_ERASE_WRITE_PAGE: decode_command = OP_ERASE_WRITE_PAGE;
			CMD_ERASE_WRITE_LOCK: decode_command = OP_ERASE_WRITE_LOCK;
			CMD_ERASE_EVERYTHING: decode_command = OP_ERASE_EVERYTHING;
			CMD_SET_LOCK: decode_command = OP_SET_LOCK;
			CMD_CLEAR_LOCK: decode_command = OP_CLEAR_LOCK;
			CMD_GET_LOCK: decode_command = OP_GET_LOCK;
			CMD_SET_NVM_BIT: decode_command = OP_SET_NVM_BIT;
			CMD_CLEAR_NVM_BIT: decode_command = OP_CLEAR_NVM_BIT;
			CMD_GET_NVM_BIT: decode_command = OP_GET_NVM_BIT;
			CMD_SET_SECURITY: decode_command = OP_SET_SECURITY;
			CMD_GET_SECURITY: decode_command = OP_GET_SECURITY;
			CMD_WRITE_MEMORY: decode_command = OP_WRITE_MEMORY;
			CMD_SELECT_CONTROLLER: decode_command = OP_SELECT_CONTROLLER;
			CMD_GET_VERSION: decode_command = OP_GET_VERSION;
			default: decode_command = OP_NONE;
		endcase
	endfunction

	// ==========================================================
	// Handshake state
	pfp_state_t state;
	pfp_state_t next_state;
	logic [3:0] sel_latched;
	logic [DATA_WIDTH-1:0] data_latched;
	logic [7:0] exec_count;
	logic port_enabled;
	logic is_read;

	assign port_enabled = test_select & program_select_0
		& program_select_1;
	assign is_read = (sel_latched == SEL_DATA) && !output_enable_n;

	always_comb
	begin
		next_state = state;
		case (state)
			ST_IDLE:
				if (port_enabled && !command_strobe_n)
					next_state = ST_LATCH;
			ST_LATCH:
				next_state = ST_EXECUTE;
			ST_EXECUTE:
				if (exec_count == 8'h00)
				begin
					if (sel_latched == SEL_DATA && !output_enable_n)
						next_state = ST_DRIVE;
					else
						next_state = ST_WAIT_HIGH;
				end
			ST_DRIVE:
				if (output_enable_n)
					next_state = ST_RELEASE;
			ST_RELEASE:
				next_state = ST_WAIT_HIGH;
			ST_WAIT_HIGH:
				if (command_strobe_n)
					next_state = ST_IDLE;
			default:
				next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state <= ST_IDLE;
		else if (clk_en)
			state <= next_state;
	end

	// Selector and data are captured once, on the strobe fall.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sel_latched <= 4'h0;
			data_latched <= '0;
		end
		else if (clk_en && state == ST_IDLE && port_enabled
			&& !command_strobe_n)
		begin
			sel_latched <= transfer_selector;
			data_latched <= port_data_bus_in;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			exec_count <= 8'h00;
		else if (clk_en)
		begin
			if (state == ST_LATCH)
				exec_count <= 8'(EXEC_CYCLES - 1);
			else if (state == ST_EXECUTE && exec_count != 8'h00)
				exec_count <= exec_count - 8'h01;
		end
	end

	// Ready is low from the latch until the strobe has returned high.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			port_ready <= 1'b1;
		else if (clk_en)
			port_ready <= (next_state == ST_IDLE);
	end

	// ==========================================================
	// Register updates
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			command_word <= COMMAND_RESET;
			operation <= OP_NONE;
			command_valid <= 1'b0;
		end
		else if (clk_en)
		begin
			command_valid <= 1'b0;
			if (state == ST_LATCH && sel_latched == SEL_COMMAND_ENTRY
				&& decode_command(data_latched) != OP_NONE)
			begin
				command_word <= data_latched;
				operation <= decode_command(data_latched);
				command_valid <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			flash_address <= ADDR_WIDTH'(ADDRESS_RESET);
		else if (clk_en)
		begin
			if (state == ST_LATCH)
			begin
				case (sel_latched)
					SEL_ADDRESS_BYTE_LOW:
						flash_address[7:0] <= data_latched[7:0];
					SEL_ADDRESS_BYTE_NEXT:
						flash_address[15:8] <= data_latched[7:0];
					default:
						flash_address <= flash_address;
				endcase
			end
			else if ((state == ST_WAIT_HIGH) && command_strobe_n
				&& sel_latched == SEL_DATA)
				flash_address <= flash_address + ADDR_WIDTH'(1);
		end
	end

	// Data writes go out as a one-cycle strobe for the flash side.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			flash_write_valid <= 1'b0;
			flash_write_data <= '0;
		end
		else if (clk_en)
		begin
			flash_write_valid <= 1'b0;
			if (state == ST_LATCH && sel_latched == SEL_DATA
				&& output_enable_n && operation != OP_NONE)
			begin
				flash_write_valid <= 1'b1;
				flash_write_data <= data_latched;
			end
		end
	end

	// ==========================================================
	// Read path and bus direction
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			port_data_bus_out <= '0;
			port_data_bus_oe <= 1'b0;
			output_valid_n <= 1'b0;
			flash_read_strobe <= 1'b0;
		end
		else if (clk_en)
		begin
			flash_read_strobe <= 1'b0;
			if (state == ST_EXECUTE && next_state == ST_DRIVE && is_read)
			begin
				port_data_bus_out <= flash_read_data;
				port_data_bus_oe <= 1'b1;
				output_valid_n <= 1'b1;
				flash_read_strobe <= 1'b1;
			end
			else if (state == ST_DRIVE && output_enable_n)
			begin
				port_data_bus_oe <= 1'b0;
				output_valid_n <= 1'b0;
			end
		end
	end

	// ==========================================================
	// External clock detection
	logic ext_prev;
	logic [15:0] ext_gap;
	logic clock_decided;
	// The gap starts saturated, so a lone edge after reset does not count.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ext_prev <= 1'b0;
			ext_gap <= 16'hffff;
			use_external_clock <= 1'b0;
			clock_decided <= 1'b0;
		end
		else if (clk_en)
		begin
			ext_prev <= external_clock_in;
			// The clock choice is final once the first strobe is taken.
			if (state == ST_IDLE && next_state == ST_LATCH)
				clock_decided <= 1'b1;
			if (external_clock_in && !ext_prev)
			begin
				ext_gap <= 16'h0000;
				if (!clock_decided && ext_gap < 16'(EXT_CLOCK_WINDOW))
					use_external_clock <= 1'b1;
			end
			else if (ext_gap != 16'hffff)
				ext_gap <= ext_gap + 16'h0001;
		end
	end

endmodule
`default_nettype wire

// file: pfp_port_props.sv
// Checker of the parallel flash programming port handshake.
`timescale 1ns/10ps
`default_nettype none
module pfp_port_props
	import pfp_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic test_select,
	input wire logic program_select_0,
	input wire logic program_select_1,
	input wire logic command_strobe_n,
	input wire logic output_enable_n,
	input wire logic [3:0] transfer_selector,
	input wire logic [15:0] port_data_bus_in,
	input wire logic port_data_bus_oe,
	input wire logic port_ready,
	input wire logic output_valid_n,
	input wire logic [15:0] command_word,
	input wire logic flash_write_valid,
	input wire logic [15:0] flash_write_data,
	input wire logic command_valid
);
	// ==========================================================
	// Handshake properties
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (rst);
	logic sel_on;
	assign sel_on = test_select && program_select_0 && program_select_1;
	a_ready_drop: assert property (
		port_ready && !command_strobe_n && sel_on |-> ##2 !port_ready)
		else $error("ready did not drop after a strobe");
	a_ready_hold: assert property (
		!port_ready && !command_strobe_n |=> !port_ready)
		else $error("ready rose while strobe low");
	a_ready_rise: assert property (
		$rose(port_ready) |-> $past(command_strobe_n))
		else $error("ready rose without strobe high");
	a_valid_dir: assert property (
		output_valid_n == port_data_bus_oe)
		else $error("valid flag disagrees with bus direction");
	a_bus_release: assert property (
		output_enable_n && port_data_bus_oe |=> !port_data_bus_oe)
		else $error("bus not released after output enable rose");
	a_cmd_store: assert property (
		command_valid |-> $past(transfer_selector, 2) == SEL_COMMAND_ENTRY
		&& command_word == $past(port_data_bus_in, 2))
		else $error("command word not the latched word");
	a_write_data: assert property (
		flash_write_valid |-> $past(transfer_selector, 2) == SEL_DATA
		&& flash_write_data == $past(port_data_bus_in, 2))
		else $error("write data not the latched word");
	a_refuse: assert property (
		!sel_on && port_ready |=> port_ready)
		else $error("strobe taken outside programming mode");
endmodule
bind pfp_port pfp_port_props chk (.clk, .rst, .test_select,
	.program_select_0, .program_select_1, .command_strobe_n,
	.output_enable_n, .transfer_selector, .port_data_bus_in,
	.port_data_bus_oe, .port_ready, .output_valid_n, .command_word,
	.flash_write_valid, .flash_write_data, .command_valid);
`default_nettype wire

// file: pfp_programmer.sv
// Behavioural gang programmer driving the port handshake.
`timescale 1ns/10ps
`default_nettype none
module pfp_programmer
(
	input wire logic clk,
	input wire logic port_ready,
	input wire logic output_valid_n,
	input wire logic [15:0] bus_from_device,
	output logic command_strobe_n,
	output logic output_enable_n,
	output logic [3:0] transfer_selector,
	output logic [15:0] bus_to_device
);
	// ==========================================================
	// Handshake tasks
	// Released lines float to the pulled-up level.
	initial
	begin
		command_strobe_n = 1'b1;
		output_enable_n = 1'b1;
		transfer_selector = 4'hf;
		bus_to_device = 16'hffff;
	end
	task automatic step();
		@(posedge clk);
		#1;
	endtask
	task automatic wait_on(input bit vld, input logic lvl);
		for (int n = 0; n < 64; n++)
		begin
			if ((vld ? output_valid_n : port_ready) === lvl)
				break;
			step();
		end
	endtask
	task automatic hs_write(input logic [3:0] sel, input logic [15:0] data);
		wait_on(0, 1'b1);
		transfer_selector = sel;
		bus_to_device = data;
		step();
		command_strobe_n = 1'b0;
		wait_on(0, 1'b0);
		transfer_selector = 4'hf;
		bus_to_device = 16'hffff;
		step();
		command_strobe_n = 1'b1;
		wait_on(0, 1'b1);
	endtask
	task automatic hs_read(output logic [15:0] data);
		wait_on(0, 1'b1);
		transfer_selector = 4'h5;
		step();
		command_strobe_n = 1'b0;
		wait_on(0, 1'b0);
		output_enable_n = 1'b0;
		wait_on(1, 1'b1);
		data = bus_from_device;
		output_enable_n = 1'b1;
		wait_on(1, 1'b0);
		transfer_selector = 4'hf;
		command_strobe_n = 1'b1;
		wait_on(0, 1'b1);
	endtask
	task automatic hold_strobe(input int n);
		command_strobe_n = 1'b0;
		repeat (n) step();
		command_strobe_n = 1'b1;
	endtask
endmodule
`default_nettype wire

// file: pfp_port_tb.sv
// Self-checking testbench of the parallel flash programming port.
`timescale 1ns/10ps
`default_nettype none
module parallel_flash_programming_port_tb_top import pfp_pkg::*;;
	logic clk, rst, tsel, ext_clk, stb_n, oe_n, boe, rdy, vld_n, use_ext;
	logic [3:0] sel;
	logic [15:0] bprog, bus, bout, cmd, d;
	logic [31:0] addr;
	logic [4:0] op;
	logic ps0, ps1, wr_v, rd_s, cv;
	logic [15:0] wr_d, wr_last;
	int wr_count = 0;
	int rd_count = 0;
	int cv_count = 0;
	int mismatches = 0;
	int checked = 0;
	logic [15:0] codes [17] = '{CMD_READ, CMD_PAGE_WRITE, CMD_PAGE_WRITE_LOCK,
		CMD_ERASE_WRITE_PAGE, CMD_ERASE_WRITE_LOCK, CMD_ERASE_EVERYTHING,
		CMD_SET_LOCK, CMD_CLEAR_LOCK, CMD_GET_LOCK, CMD_SET_NVM_BIT,
		CMD_CLEAR_NVM_BIT, CMD_GET_NVM_BIT, CMD_SET_SECURITY, CMD_GET_SECURITY,
		CMD_WRITE_MEMORY, CMD_SELECT_CONTROLLER, CMD_GET_VERSION};
	assign bus = boe ? bout : bprog;
	pfp_port uut (.clk(clk), .rst(rst), .clk_en(1'b1), .test_select(tsel),
		.program_select_0(ps0), .program_select_1(ps1),
		.external_clock_in(ext_clk), .command_strobe_n(stb_n),
		.output_enable_n(oe_n), .transfer_selector(sel),
		.port_data_bus_in(bus), .port_data_bus_out(bout),
		.port_data_bus_oe(boe), .port_ready(rdy), .output_valid_n(vld_n),
		.use_external_clock(use_ext), .command_word(cmd),
		.flash_address(addr), .flash_write_valid(wr_v),
		.flash_write_data(wr_d), .flash_read_strobe(rd_s),
		.flash_read_data(addr[15:0] ^ 16'ha5a5),
		.command_valid(cv), .operation(op));
	// Pulses stand one cycle, so each is counted once at the falling edge.
	always @(negedge clk)
	begin
		if (wr_v)
		begin
			wr_count++;
			wr_last = wr_d;
		end
		if (rd_s)
			rd_count++;
		if (cv)
			cv_count++;
	end
	pfp_programmer prog (.clk(clk), .port_ready(rdy), .output_valid_n(vld_n),
		.bus_from_device(bus), .command_strobe_n(stb_n),
		.output_enable_n(oe_n), .transfer_selector(sel),
		.bus_to_device(bprog));
	// ==========================================================
	// Checking and scenarios
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		if (mismatches == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic t_commands();
		for (int i = 0; i < 17; i++)
		begin
			prog.hs_write(SEL_COMMAND_ENTRY, codes[i]);
			chk(cmd, codes[i]);
			chk(op, i + 1);
		end
		prog.hs_write(SEL_COMMAND_ENTRY, 16'h0099);
		chk(cmd, CMD_GET_VERSION);
		chk(op, OP_GET_VERSION);
		prog.hs_write(4'h7, 16'h00aa);
		chk(addr, 32'h0);
		chk(cmd, CMD_GET_VERSION);
		chk(cv_count, 17);
	endtask
	task automatic t_write();
		prog.hs_write(SEL_COMMAND_ENTRY, CMD_PAGE_WRITE);
		prog.hs_write(SEL_ADDRESS_BYTE_LOW, 16'h00fe);
		prog.hs_write(SEL_ADDRESS_BYTE_NEXT, 16'h0012);
		chk(addr, 32'h12fe);
		for (int i = 0; i < 2; i++)
		begin
			prog.hs_write(SEL_DATA, 16'hc3c3 ^ 16'(i));
			chk(addr, 32'h12ff + i);
		end
		chk(wr_count, 2);
		chk(wr_last, 16'hc3c2);
	endtask
	task automatic t_read();
		prog.hs_write(SEL_COMMAND_ENTRY, CMD_READ);
		prog.hs_write(SEL_ADDRESS_BYTE_LOW, 16'h0040);
		prog.hs_write(SEL_ADDRESS_BYTE_NEXT, 16'h0003);
		for (int i = 0; i < 2; i++)
		begin
			prog.hs_read(d);
			chk(d, (16'h0340 + 16'(i)) ^ 16'ha5a5);
			chk(addr, 32'h0341 + i);
		end
		chk(rd_count, 2);
		chk(wr_count, 2);
		tsel = 1'b0;
		prog.hold_strobe(6);
		chk(rdy, 1);
		tsel = 1'b1;
		ps0 = 1'b0;
		prog.hold_strobe(6);
		chk(rdy, 1);
		ps0 = 1'b1;
		ps1 = 1'b0;
		prog.hold_strobe(6);
		chk(rdy, 1);
		chk(cmd, CMD_READ);
		chk(addr, 32'h0342);
		ps1 = 1'b1;
	endtask
	// Eight periods of 100 clock cycles on the external clock pin.
	task automatic toggle_ext();
		repeat (16)
		begin
			repeat (50) @(posedge clk);
			#1;
			ext_clk = ~ext_clk;
		end
	endtask
	task automatic t_extclk();
		toggle_ext();
		prog.hs_write(SEL_COMMAND_ENTRY, CMD_GET_LOCK);
		chk(use_ext, 0);
		rst = 1'b1;
		repeat (6) @(posedge clk);
		#1;
		rst = 1'b0;
		chk(use_ext, 0);
		chk(rdy, 1);
		chk(cmd, COMMAND_RESET);
		toggle_ext();
		prog.hs_write(SEL_COMMAND_ENTRY, CMD_GET_VERSION);
		chk(use_ext, 1);
		chk(cmd, CMD_GET_VERSION);
	endtask
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		rst = 1'b1;
		tsel = 1'b1;
		ps0 = 1'b1;
		ps1 = 1'b1;
		ext_clk = 1'b0;
		repeat (6) @(posedge clk);
		#1;
		rst = 1'b0;
		chk(rdy, 1);
		chk(vld_n, 0);
		chk(use_ext, 0);
		t_commands();
		t_write();
		t_read();
		t_extclk();
		print_verdict();
	end
	initial
	begin
		#300000;
		mismatches++;
		print_verdict();
	end
endmodule
`default_nettype wire
